// [core/wpos_cfg.svh]
// Purpose: Constants of the two-wire wiper position slave.
// Assumes: Included by bare name from the design files.
// Notes: Sizes, opcodes and reset values of the serial protocol live here; field positions are decoded in the slave.
`ifndef WPOS_CFG_SVH
`define WPOS_CFG_SVH
`define WPOS_SEGMENTS 255
`define WPOS_TAPS 256
`define WPOS_NSTORE 16
// Device type identifier; the value is arbitrary.
`define WPOS_DEV_ID 4'hA
`define WPOS_OP_RD_WIPER 3'h4
`define WPOS_OP_RD_STORE 3'h5
`define WPOS_OP_WR_STORE 3'h6
`define WPOS_OP_WR_WIPER 3'h7
`define WPOS_OP_XFER_TO_STORE 3'h2
`define WPOS_OP_XFER_TO_WIPER 3'h3
`define WPOS_STORE_RST 8'h80
`define WPOS_WIPER_RST 8'h00
`define WPOS_BITS_PER_BYTE 4'h8
`endif

// [core/wpos_pkg.sv]
// Purpose: Types of the two-wire wiper position slave.
// Assumes: Nothing beyond the constants header.
// Notes: Protocol phases of the serial slave.
`default_nettype none
package wpos_pkg;
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_INSTR, ST_INSTR_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK
  } wpos_state_t;
endpackage
`default_nettype wire

// [core/wpos_tap_decode.sv]
// Purpose: One-hot decode of the wiper position onto the tap switches.
// Assumes: Position is eight bits.
// Notes: Purely combinational.
`timescale 1ns/1ps
`default_nettype none
`include "wpos_cfg.svh"
module wpos_tap_decode (
  input wire logic [7:0] position, // wiper position
  output logic [`WPOS_TAPS-1:0] tap_sel // one-hot tap switch enables
);
  assign tap_sel = {{(`WPOS_TAPS-1){1'b0}}, 1'b1} << position;
endmodule // wpos_tap_decode
`default_nettype wire

// [core/wpos_slave.sv]
// Purpose: Two-wire slave holding one wiper position and 16 stored positions.
// Assumes: Bus pins are asynchronous to clk and far slower than 100 MHz.
// Notes: Stored positions are flip-flops standing in for non-volatile cells.
`timescale 1ns/1ps
`default_nettype none
`include "wpos_cfg.svh"
// Functional notes
// [R1] Model a chain of 255 segments; every tap point can reach the wiper.
// [R2] A volatile wiper position register selects the tap joined to wiper.
// [R3] After reset the default stored position is loaded into the wiper.
// [R4] Sixteen stored position registers, each writable and readable over bus.
// [R5] Address, opcode, pointer and data bits are sampled on rising clock.
// [R6] Returned bits change only after a falling edge of the serial clock.
// [R7] The data line is open drain: pulled low or released.
// [R8] Straps give the low three address bits; the fourth is grounded.
// [R9] Take part only when the received address matches the straps.
// [R10] At most eight such devices share one bus, each distinct.
// [R11] The master makes the serial clock; the device never drives it.
// [R12] With write protect low, stored position writes are refused.
// [R13] Acknowledge address, command byte and the following data byte.
// [R14] Eight-bit wiper decoded so exactly one of 256 taps is on.
module wpos_slave (
  input wire logic clk, // 100 MHz clock
  input wire logic rst, // synchronous reset, active high
  input wire logic scl_i, // serial clock pin
  input wire logic sda_i, // serial data pin level
  output logic sda_o, // serial data drive value, always low
  output logic sda_oe_n, // low while the data line is pulled low
  input wire logic address_strap_bit0, // address strap
  input wire logic address_strap_bit1, // address strap
  input wire logic address_strap_bit2, // address strap
  input wire logic address_strap_bit3_grounded, // strap tied low
  input wire logic write_protect_n, // low blocks stored position writes
  output logic [7:0] wiper_position, // wiper position register
  output logic [`WPOS_TAPS-1:0] tap_sel // one-hot tap switch enables
);
  function automatic logic [2:0] op_of(input logic [7:0] b);
    return b[7:5];
  endfunction

  logic [6:0] sync1_q;
  logic [6:0] sync2_q;
  logic scl_q3;
  logic sda_q3;
  wpos_pkg::wpos_state_t state_q;
  logic [3:0] bitcnt_q;
  logic [7:0] shift_q;
  logic [7:0] instr_q;
  logic [7:0] tx_q;
  logic drive_q;
  logic recall_q;
  logic is_rd_q;
  logic is_wr_q;
  logic [7:0] wiper_position_register;
  logic [7:0] store_q [`WPOS_NSTORE];

  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_q <= 7'h7F;
      sync2_q <= 7'h7F;
      scl_q3 <= 1'b1;
      sda_q3 <= 1'b1;
    end else begin
      sync1_q <= {write_protect_n, address_strap_bit3_grounded,
                  address_strap_bit2, address_strap_bit1,
                  address_strap_bit0, sda_i, scl_i};
      sync2_q <= sync1_q;
      scl_q3 <= sync2_q[0];
      sda_q3 <= sync2_q[1];
    end
  end

  wire scl_s = sync2_q[0];
  wire sda_s = sync2_q[1];
  wire [3:0] straps = sync2_q[5:2];
  wire wp_ok = sync2_q[6];
  wire scl_rise = scl_s & ~scl_q3; // [R5]
  wire scl_fall = ~scl_s & scl_q3; // [R6]
  wire start_ev = scl_s & scl_q3 & sda_q3 & ~sda_s;
  wire stop_ev = scl_s & scl_q3 & ~sda_q3 & sda_s;
  wire byte_full = bitcnt_q == `WPOS_BITS_PER_BYTE;
  wire byte_end = scl_fall & byte_full & ~start_ev & ~stop_ev;
  wire addr_hit = shift_q == {`WPOS_DEV_ID, straps}; // [R8] [R9]
  wire rx_state = state_q == wpos_pkg::ST_ADDR ||
                  state_q == wpos_pkg::ST_INSTR ||
                  state_q == wpos_pkg::ST_WDATA;
  wire instr_end = byte_end & state_q == wpos_pkg::ST_INSTR;
  wire wdata_end = byte_end & state_q == wpos_pkg::ST_WDATA;
  wire bank0 = shift_q[3:2] == 2'b00;
  wire [2:0] new_op = op_of(shift_q);
  wire [2:0] cur_op = op_of(instr_q);
  wire is_rd = new_op == `WPOS_OP_RD_WIPER || new_op == `WPOS_OP_RD_STORE;
  wire is_wr = new_op == `WPOS_OP_WR_WIPER || new_op == `WPOS_OP_WR_STORE;
  wire st_req = (wdata_end & cur_op == `WPOS_OP_WR_STORE) |
                (instr_end & new_op == `WPOS_OP_XFER_TO_STORE & bank0);
  wire st_we = st_req & wp_ok; // [R12]
  wire [3:0] st_idx = wdata_end ? instr_q[3:0] : shift_q[3:0];
  wire [7:0] st_wdata = wdata_end ? shift_q : wiper_position_register;
  wire wp_we = (wdata_end & cur_op == `WPOS_OP_WR_WIPER) |
               (instr_end & new_op == `WPOS_OP_XFER_TO_WIPER & bank0);
  wire [7:0] wp_wdata = wdata_end ? shift_q : store_q[shift_q[3:0]];
  wire [7:0] rd_val = new_op == `WPOS_OP_RD_WIPER ?
                      wiper_position_register : store_q[shift_q[3:0]];

  // Serial protocol sequencer; start and stop override any phase.
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= wpos_pkg::ST_IDLE;
      bitcnt_q <= 4'h0;
      shift_q <= 8'h00;
      instr_q <= 8'h00;
      tx_q <= 8'h00;
      drive_q <= 1'b0;
    end else if (start_ev) begin
      state_q <= wpos_pkg::ST_ADDR;
      bitcnt_q <= 4'h0;
      drive_q <= 1'b0;
    end else if (stop_ev) begin
      state_q <= wpos_pkg::ST_IDLE;
      drive_q <= 1'b0;
    end else begin
      if (scl_rise && rx_state && !byte_full) begin
        shift_q <= {shift_q[6:0], sda_s}; // [R5]
        bitcnt_q <= bitcnt_q + 4'h1;
      end
      if (scl_rise && state_q == wpos_pkg::ST_RDATA)
        bitcnt_q <= bitcnt_q + 4'h1;
      unique case (state_q)
        wpos_pkg::ST_ADDR: if (byte_end) begin
          bitcnt_q <= 4'h0;
          drive_q <= addr_hit; // [R13]
          state_q <= addr_hit ? wpos_pkg::ST_ADDR_ACK : wpos_pkg::ST_IDLE;
        end
        wpos_pkg::ST_ADDR_ACK: if (scl_fall) begin
          drive_q <= 1'b0;
          state_q <= wpos_pkg::ST_INSTR;
        end
        wpos_pkg::ST_INSTR: if (byte_end) begin
          bitcnt_q <= 4'h0;
          instr_q <= shift_q;
          tx_q <= rd_val;
          drive_q <= 1'b1; // [R13]
          state_q <= wpos_pkg::ST_INSTR_ACK;
        end
        wpos_pkg::ST_INSTR_ACK: if (scl_fall) begin
          drive_q <= is_rd_q & ~tx_q[7]; // [R6]
          state_q <= is_rd_q ? wpos_pkg::ST_RDATA :
                     is_wr_q ? wpos_pkg::ST_WDATA : wpos_pkg::ST_IDLE;
        end
        wpos_pkg::ST_WDATA: if (byte_end) begin
          bitcnt_q <= 4'h0;
          drive_q <= 1'b1; // [R13]
          state_q <= wpos_pkg::ST_WDATA_ACK;
        end
        wpos_pkg::ST_WDATA_ACK: if (scl_fall) begin
          drive_q <= 1'b0;
          state_q <= wpos_pkg::ST_IDLE;
        end
        wpos_pkg::ST_RDATA: if (scl_fall) begin
          if (byte_full) begin
            bitcnt_q <= 4'h0;
            drive_q <= 1'b0;
            state_q <= wpos_pkg::ST_RDATA_ACK;
          end else if (bitcnt_q != 4'h0) begin
            tx_q <= {tx_q[6:0], 1'b0};
            drive_q <= ~tx_q[6]; // [R6]
          end
        end
        wpos_pkg::ST_RDATA_ACK: if (scl_fall)
          state_q <= wpos_pkg::ST_IDLE;
        wpos_pkg::ST_IDLE: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      is_rd_q <= 1'b0;
      is_wr_q <= 1'b0;
    end else if (instr_end) begin
      is_rd_q <= is_rd;
      is_wr_q <= is_wr;
    end
  end

  // Stored positions; flip-flops stand in for the non-volatile cells.
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < `WPOS_NSTORE; i++)
        store_q[i] <= `WPOS_STORE_RST;
    end else if (st_we) begin
      store_q[st_idx] <= st_wdata; // [R4]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      recall_q <= 1'b1;
      wiper_position_register <= `WPOS_WIPER_RST;
    end else if (recall_q) begin
      recall_q <= 1'b0;
      wiper_position_register <= store_q[0]; // [R3]
    end else if (wp_we) begin
      wiper_position_register <= wp_wdata; // [R2]
    end
  end

  assign sda_o = 1'b0; // [R7]
  assign sda_oe_n = ~drive_q; // [R7]
  assign wiper_position = wiper_position_register;

  // Each of the 255 segments lies between two of the switched taps.
  wpos_tap_decode u_decode (
    .position(wiper_position_register), // [R1] [R14]
    .tap_sel(tap_sel)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_addr_done;
    state_q == wpos_pkg::ST_ADDR ##0 byte_end;
  endsequence
  sequence s_ack_low;
    !sda_oe_n && state_q == wpos_pkg::ST_ADDR_ACK;
  endsequence

  chk_tap_onehot: assert property ($onehot(tap_sel)) // [R14]
    else $error("tap select is not one-hot");
  chk_tap_matches: assert property (tap_sel[wiper_position] == 1'b1) // [R1]
    else $error("selected tap differs from wiper position");
  chk_power_recall: assert property ($fell(rst) |=>
    wiper_position == $past(store_q[0])) // [R3]
    else $error("default stored position not recalled");
  chk_wiper_cause: assert property ($changed(wiper_position) |->
    $past(wp_we) || $past(recall_q)) // [R2]
    else $error("wiper changed without a write");
  chk_addr_ack: assert property (s_addr_done ##0 addr_hit |=>
    s_ack_low) // [R13]
    else $error("address not acknowledged");
  chk_addr_mismatch: assert property (s_addr_done ##0 !addr_hit |=>
    state_q == wpos_pkg::ST_IDLE && sda_oe_n) // [R9]
    else $error("foreign address answered");
  chk_sda_on_fall: assert property ($fell(sda_oe_n) || $rose(sda_oe_n) |->
    $past(scl_fall) || $past(start_ev) || $past(stop_ev)) // [R6]
    else $error("data line changed outside a falling edge");
  chk_wp_refuse: assert property (st_req && !wp_ok |=>
    store_q[$past(st_idx)] == $past(store_q[st_idx])) // [R12]
    else $error("stored write not refused under protect");
  chk_store_write: assert property (st_we |=>
    store_q[$past(st_idx)] == $past(st_wdata)) // [R4]
    else $error("stored write lost");
  chk_sample_rise: assert property ($changed(shift_q) && !rst |->
    $past(scl_rise)) // [R5]
    else $error("bit sampled off the rising edge");
endmodule // wpos_slave
`default_nettype wire

// [verif/wpos_bus_master.sv]
// Purpose: Behavioural two-wire bus master that drives the wiper slave.
// Assumes: Data line has a pull-up; bit timing counted in system clocks.
// Notes: Also counts slave line changes made more than four system clocks into a clock high phase.
`timescale 1ns/1ps
`default_nettype none
module wpos_bus_master #(
  parameter int HALF = 6
) (
  input wire logic clk, // system clock used to time the bits
  input wire logic sda_line, // resolved data line level
  input wire logic sda_oe_n, // slave pull-down enable, active low
  input wire logic sda_o, // slave drive value
  output logic scl, // serial clock to the slave
  output logic sda_low // high while the master pulls data low
);
  int high_cnt;
  int violations;
  logic oe_n_q;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    high_cnt = 0;
    violations = 0;
    oe_n_q = 1'b1;
  end
  // A slave edge late in a clock high phase would corrupt the sampled bit.
  always @(posedge clk) begin
    high_cnt <= scl ? high_cnt + 1 : 0;
    oe_n_q <= sda_oe_n;
    if (high_cnt > 4 && sda_oe_n !== oe_n_q) violations <= violations + 1;
    if (sda_oe_n === 1'b0 && sda_o !== 1'b0) violations <= violations + 1;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic start();
    sda_low = 1'b0;
    scl = 1'b1;
    tick(HALF);
    sda_low = 1'b1;
    tick(HALF);
    scl = 1'b0;
  endtask
  task automatic stop();
    tick(HALF / 2);
    sda_low = 1'b1;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    sda_low = 1'b0;
    tick(HALF);
  endtask
  // Data moves only well inside the clock low phase.
  task automatic bit_cycle(input logic b, output logic got);
    tick(HALF / 2);
    sda_low = ~b;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    got = sda_line;
    scl = 1'b0;
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) bit_cycle(b[i], g);
    bit_cycle(1'b1, g);
    ack = ~g;
  endtask
  task automatic rbyte(output logic [7:0] d);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b1, g);
      d[i] = g;
    end
    bit_cycle(1'b1, g);
  endtask
endmodule // wpos_bus_master
`default_nettype wire

// [verif/test_two_wire_wiper_position_slave.sv]
// Purpose: Self-checking bench of the two-wire wiper position slave.
// Assumes: Straps set to 101; the fourth strap is grounded.
// Notes: Each scenario is a task that judges the result; all but t_recall drive the bus first.
`timescale 1ns/1ps
`default_nettype none
`include "wpos_cfg.svh"
module test_two_wire_wiper_position_slave;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wp_n = 1'b1;
  logic scl, m_low, sda_line, sda_o, sda_oe_n;
  logic [7:0] wiper;
  logic [255:0] taps;
  int miscompares = 0;
  int total_checks = 0;
  localparam logic [7:0] ADDR = {`WPOS_DEV_ID, 1'b0, 3'b101};
  always #5 clk = ~clk;
  assign sda_line = ~(m_low | ~sda_oe_n);
  wpos_bus_master M (.clk(clk), .sda_line(sda_line), .sda_oe_n(sda_oe_n),
    .sda_o(sda_o), .scl(scl), .sda_low(m_low));
  wpos_slave DUT (.clk(clk), .rst(rst), .scl_i(scl), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe_n(sda_oe_n), .address_strap_bit0(1'b1),
    .address_strap_bit1(1'b0), .address_strap_bit2(1'b1),
    .address_strap_bit3_grounded(1'b0), .write_protect_n(wp_n),
    .wiper_position(wiper), .tap_sel(taps));
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] a, input logic [7:0] ins,
      input logic [7:0] dat, input bit rd, output logic [7:0] acks,
      output logic [7:0] rdat);
    acks = 8'h00;
    rdat = 8'h00;
    M.start();
    M.wbyte(a, acks[2]);
    if (acks[2]) begin
      M.wbyte(ins, acks[1]);
      if (rd) M.rbyte(rdat);
      else M.wbyte(dat, acks[0]);
    end
    M.stop();
  endtask
  task automatic t_recall();
    check(wiper, `WPOS_STORE_RST);
    check({7'h00, taps[8'h80]}, 8'h01);
    check(8'($countones(taps)), 8'h01);
    $display("test recall done");
  endtask
  task automatic t_write_wiper();
    logic [7:0] a, r;
    cmd(ADDR, {`WPOS_OP_WR_WIPER, 5'h00}, 8'h33, 1'b0, a, r);
    check(a, 8'h07);
    check(wiper, 8'h33);
    check({7'h00, taps[8'h33]}, 8'h01);
    check(8'($countones(taps)), 8'h01);
    $display("test write_wiper done");
  endtask
  task automatic t_bad_addr();
    logic [7:0] a, r;
    for (int i = 0; i < 4; i++) begin
      cmd(ADDR ^ (8'h01 << i), {`WPOS_OP_WR_WIPER, 5'h00}, 8'h44, 1'b0, a, r);
      check(a, 8'h00);
    end
    check(wiper, 8'h33);
    $display("test bad_addr done");
  endtask
  task automatic t_store();
    logic [7:0] a, r;
    for (int i = 0; i < 16; i += 5) begin
      cmd(ADDR, {`WPOS_OP_WR_STORE, 1'b0, 4'(i)}, 8'h5A ^ 8'(i), 1'b0, a, r);
      check(a, 8'h07);
      cmd(ADDR, {`WPOS_OP_RD_STORE, 1'b0, 4'(i)}, 8'h00, 1'b1, a, r);
      check(r, 8'h5A ^ 8'(i));
    end
    $display("test store done");
  endtask
  task automatic t_protect();
    logic [7:0] a, r;
    wp_n = 1'b0;
    cmd(ADDR, {`WPOS_OP_WR_STORE, 5'h05}, 8'h11, 1'b0, a, r);
    check(a, 8'h07);
    wp_n = 1'b1;
    cmd(ADDR, {`WPOS_OP_RD_STORE, 5'h05}, 8'h00, 1'b1, a, r);
    check(r, 8'h5F);
    $display("test protect done");
  endtask
  task automatic t_read_wiper();
    logic [7:0] a, r;
    cmd(ADDR, {`WPOS_OP_RD_WIPER, 5'h00}, 8'h00, 1'b1, a, r);
    check(r, 8'h33);
    cmd(ADDR, {`WPOS_OP_XFER_TO_WIPER, 5'h00}, 8'h00, 1'b1, a, r);
    check(wiper, 8'h5A);
    check({7'h00, taps[8'h5A]}, 8'h01);
    cmd(ADDR, {`WPOS_OP_XFER_TO_STORE, 5'h01}, 8'h00, 1'b1, a, r);
    cmd(ADDR, {`WPOS_OP_RD_STORE, 5'h01}, 8'h00, 1'b1, a, r);
    check(r, 8'h5A);
    cmd(ADDR, {`WPOS_OP_XFER_TO_WIPER, 5'h05}, 8'h00, 1'b1, a, r);
    check(wiper, 8'h5A);
    check(8'(M.violations), 8'h00);
    $display("test read_wiper done");
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    wrap_up();
  end
  initial begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (6) @(negedge clk);
    t_recall();
    t_write_wiper();
    t_bad_addr();
    t_store();
    t_protect();
    t_read_wiper();
    wrap_up();
  end
endmodule // test_two_wire_wiper_position_slave
`default_nettype wire
